// ---- swc_map.svh ----
// Constants of the sleep and wake-up controller: register indices,
// field positions, reset values and timing counts.
// Assumes a 10 MHz core oscillator feeding CLOCK_I.
`ifndef SWC_MAP_SVH
`define SWC_MAP_SVH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define SWC_IDX_STATUS 14'h0003
`define SWC_IDX_IRQ_EN 14'h000b
`define SWC_IDX_OPTION 14'h0081
`define SWC_IDX_FUSE 14'h2007

// ---------------------------------------------------------------
// Reset values and field positions
// ---------------------------------------------------------------
`define SWC_OPTION_RST 8'hff
`define SWC_IRQ_EN_RST 8'h00
`define SWC_IRQ_EN_MASK 8'h8f
`define SWC_OPT_PSA 3
`define SWC_OPT_PS_MSB 2
`define SWC_FUSE_WATCHDOG_FUSE_ENABLE 3
`define SWC_FUSE_OSC_MSB 2
`define SWC_IRQ_GIE 7
`define SWC_ST_TO 4
`define SWC_ST_PD 3
`define SWC_ST_WARM 1
`define SWC_ST_ASLEEP 0
`define SWC_NUM_IRQ 4
`define SWC_IRQ_VECTOR 13'h0004

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define SWC_CLK_PERIOD_NS 100
`define SWC_TOST_TOSC 1024
`define SWC_XTAL_DELAY_CYC (`SWC_TOST_TOSC)
`define SWC_RC_DELAY_NS 1000
`define SWC_RC_DELAY_CYC ((`SWC_RC_DELAY_NS + `SWC_CLK_PERIOD_NS - 1) / `SWC_CLK_PERIOD_NS)
`define SWC_WDT_BASE_TICKS 18

// ---------------------------------------------------------------
// Bus answers
// ---------------------------------------------------------------
`define SWC_RESP_OKAY 2'b00
`define SWC_RESP_SLVERR 2'b10

`endif

// ---- swc_pkg.sv ----
// Types of the sleep and wake-up controller.
// Assumes nothing beyond a SystemVerilog compiler.
package swc_pkg;
    // Controller states, one-hot
    typedef enum logic [2:0] {
        SWC_RUN = 3'b001,
        SWC_SLEEP = 3'b010,
        SWC_WARM = 3'b100
    } swc_state_t;
    // Oscillator selection held in the fuse word
    typedef enum logic [2:0] {
        SWC_CRYSTAL_MODE_LOW_POWER = 3'h0,
        SWC_CRYSTAL_MODE_MEDIUM = 3'h1,
        SWC_CRYSTAL_MODE_HIGH = 3'h2,
        SWC_RC_MODE = 3'h3
    } swc_osc_mode_t;
endpackage

// ---- swc_delay.sv ----
// Oscillator start-up down-counter.
// Assumes load_i is a one-cycle pulse and count_i is at least one.
`timescale 1ns/1ps
`default_nettype none
module swc_delay #(
    parameter int W = 11
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic [W-1:0] count_i,
    output logic done_o
);
    logic [W-1:0] cnt_ff; // Cycles still to wait

    // Count down, pulse done in the cycle after reaching one
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_ff <= '0;
            done_o <= 1'b0;
        end else if (load_i) begin
            cnt_ff <= count_i;
            done_o <= 1'b0;
        end else begin
            done_o <= (cnt_ff == W'(1));
            if (cnt_ff != '0) begin
                cnt_ff <= cnt_ff - W'(1);
            end
        end
    end
endmodule
`default_nettype wire

// ---- swc_wdog.sv ----
// Watchdog counter counting ticks of its own slow oscillator.
// Assumes tick_i is a one-cycle pulse synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module swc_wdog #(
    parameter int TICK_W = 12,
    parameter int BASE_TICKS = 18
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic clr_i,
    input wire logic tick_i,
    input wire logic psa_i,
    input wire logic [2:0] ps_i,
    output logic timeout_o
);
    logic [TICK_W-1:0] cnt_ff; // Ticks since last clear
    logic [TICK_W-1:0] limit; // Ticks per time-out

    // Prescaler widens the period by two to the ps field
    always_comb begin
        limit = psa_i ? (TICK_W'(BASE_TICKS) << ps_i) : TICK_W'(BASE_TICKS);
    end

    // Count ticks; a disabled watchdog never times out
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || clr_i || !en_i) begin
            cnt_ff <= '0;
            timeout_o <= 1'b0;
        end else if (tick_i && cnt_ff >= limit - TICK_W'(1)) begin
            cnt_ff <= '0;
            timeout_o <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + TICK_W'(tick_i);
            timeout_o <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_wdog_fuse_off: assert property (!en_i |=> !timeout_o)
        else $error("watchdog timed out while disabled");
    chk_wdog_clear: assert property (clr_i |=> cnt_ff == '0 && !timeout_o)
        else $error("watchdog count not cleared");
endmodule
`default_nettype wire

// ---- swc_top.sv ----
// Sleep entry and wake-up controller with its watchdog and register slave.
// Assumes the core pulses SLEEP_EXEC_I and CLRWDT_I for one cycle and
// that CLOCK_I is the core oscillator; OSC_DRIVER_ON_O gates core clocks.
`timescale 1ns/1ps
`default_nettype none
`include "swc_map.svh"

// Function
// - Sleep entered only by sleep instruction
// - Sleep entry clears watchdog, keeps it running
// - Sleep entry clears power-down, sets time-out
// - Sleep entry stops main oscillator driver
// - Pins keep pre-sleep state while asleep
// - Watchdog reset never drives master clear low
// - Wake on clear, watchdog, interrupt sources
// - Master clear resets; others continue execution
// - Power-down flag set at power-up, cleared by sleep
// - Watchdog wake clears time-out flag
// - Next instruction prefetched during sleep
// - Enabled sources wake regardless of global enable
// - After interrupt wake, branch to vector if global enable
// - Pending enabled flag at sleep wakes immediately
// - Watchdog cleared on every wake-up
// - Oscillator start-up delay before resuming
// - Watchdog resets when running, wakes when asleep
// - Fuse clear disables watchdog completely
module swc_top #(
    parameter int WDT_BASE = `SWC_WDT_BASE_TICKS
) (
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    input wire logic [15:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [15:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic [7:0] FUSE_I,
    input wire logic SLEEP_EXEC_I,
    input wire logic CLRWDT_I,
    input wire logic MASTER_CLEAR_PIN_N_I,
    input wire logic WDT_TICK_I,
    input wire logic [`SWC_NUM_IRQ-1:0] IRQ_FLAG_I,
    output logic OSC_DRIVER_ON_O,
    output logic PIPE_FREEZE_O,
    output logic PREFETCH_O,
    output logic IO_HOLD_O,
    output logic DEV_RESET_O,
    output logic RESUME_O,
    output logic VECTOR_BRANCH_O,
    output logic [12:0] VECTOR_ADDR_O
);
    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    swc_pkg::swc_state_t state_ff; // Controller state
    swc_pkg::swc_state_t nxt_state; // Next controller state
    logic [7:0] option_ff; // Timer option register
    logic [7:0] irq_en_ff; // Global and per-source enables
    logic [7:0] fuse_ff; // Fuse word caught after reset
    logic fuse_valid_ff; // Fuse word has been caught
    logic power_down_flag_ff; // Low after sleep, high from power-up
    logic timeout_flag_ff; // Low after a watchdog time-out
    logic wake_irq_ff; // Wake-up was caused by an interrupt
    logic wdt_timeout; // Watchdog time-out pulse
    logic wdt_en; // Watchdog enabled by fuse
    logic wdt_clr; // Watchdog clear request
    logic delay_done; // Start-up delay expired
    logic master_clear_pin; // Master clear asserted
    logic irq_wake; // Some enabled source is flagged
    logic wake; // Any wake cause
    logic sleep_entry; // Sleep instruction taken this cycle
    logic wake_start; // Leaving sleep towards warm-up
    logic resume; // Warm-up over, core restarts
    logic xtal_mode; // Oscillator needs the long start-up
    logic [10:0] delay_cnt; // Start-up delay in cycles
    logic [13:0] aw_idx_ff; // Latched write index
    logic [7:0] wdata_ff; // Latched write data low byte
    logic wstrb0_ff; // Latched low byte lane strobe
    logic [13:0] ar_idx_ff; // Latched read index
    logic do_write; // Address and data both held
    logic do_read; // Read address held
    logic [31:0] rd_word; // Decoded read data
    logic rd_ok; // Read index is mapped
    logic wr_ok; // Write index is writable

    // ---------------------------------------------------------------
    // Wake and event conditions
    // ---------------------------------------------------------------
    // Combine the causes, interrupt sources gated by their own enables
    always_comb begin
        master_clear_pin = !MASTER_CLEAR_PIN_N_I;
        irq_wake = |(IRQ_FLAG_I & irq_en_ff[`SWC_NUM_IRQ-1:0]);
        wake = master_clear_pin || wdt_timeout || irq_wake;
        sleep_entry = (state_ff == swc_pkg::SWC_RUN) && SLEEP_EXEC_I && !master_clear_pin;
        wake_start = (state_ff == swc_pkg::SWC_SLEEP) && !master_clear_pin && (wdt_timeout || irq_wake);
        resume = (state_ff == swc_pkg::SWC_WARM) && !master_clear_pin && delay_done;
        wdt_en = fuse_valid_ff && fuse_ff[`SWC_FUSE_WATCHDOG_FUSE_ENABLE];
        wdt_clr = sleep_entry || wake_start || CLRWDT_I || master_clear_pin;
        xtal_mode = fuse_ff[`SWC_FUSE_OSC_MSB:0] inside {swc_pkg::SWC_CRYSTAL_MODE_LOW_POWER,
            swc_pkg::SWC_CRYSTAL_MODE_MEDIUM, swc_pkg::SWC_CRYSTAL_MODE_HIGH};
        delay_cnt = xtal_mode ? 11'(`SWC_XTAL_DELAY_CYC) : 11'(`SWC_RC_DELAY_CYC);
    end

    // ---------------------------------------------------------------
    // Watchdog and start-up delay
    // ---------------------------------------------------------------
    // Watchdog keeps counting through sleep on its own tick
    swc_wdog #(.TICK_W(12), .BASE_TICKS(WDT_BASE)) u_wdog (
        .clk_i(CLOCK_I),
        .rst_n_i(RST_N_I),
        .en_i(wdt_en),
        .clr_i(wdt_clr),
        .tick_i(WDT_TICK_I),
        .psa_i(option_ff[`SWC_OPT_PSA]),
        .ps_i(option_ff[`SWC_OPT_PS_MSB:0]),
        .timeout_o(wdt_timeout)
    );

    // Oscillator settles for the mode's delay before the core restarts
    swc_delay #(.W(11)) u_delay (
        .clk_i(CLOCK_I),
        .rst_n_i(RST_N_I),
        .load_i(wake_start),
        .count_i(delay_cnt),
        .done_o(delay_done)
    );

    // ---------------------------------------------------------------
    // State machine
    // ---------------------------------------------------------------
    // Next state from instruction, wake causes and delay
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            swc_pkg::SWC_RUN: begin
                if (sleep_entry) begin
                    nxt_state = swc_pkg::SWC_SLEEP;
                end
            end
            swc_pkg::SWC_SLEEP: begin
                if (master_clear_pin) begin
                    nxt_state = swc_pkg::SWC_RUN;
                end else if (wake) begin
                    nxt_state = swc_pkg::SWC_WARM;
                end
            end
            swc_pkg::SWC_WARM: begin
                if (master_clear_pin || delay_done) begin
                    nxt_state = swc_pkg::SWC_RUN;
                end
            end
            default: begin
                nxt_state = swc_pkg::SWC_RUN;
            end
        endcase
    end

    // State register
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            state_ff <= swc_pkg::SWC_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ---------------------------------------------------------------
    // Core-facing outputs
    // ---------------------------------------------------------------
    // Oscillator driver, pipeline freeze and pin hold
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            OSC_DRIVER_ON_O <= 1'b1;
            PIPE_FREEZE_O <= 1'b0;
            IO_HOLD_O <= 1'b0;
        end else begin
            if (sleep_entry) begin
                OSC_DRIVER_ON_O <= 1'b0;
            end else if (nxt_state != swc_pkg::SWC_SLEEP) begin
                OSC_DRIVER_ON_O <= 1'b1;
            end
            PIPE_FREEZE_O <= (nxt_state != swc_pkg::SWC_RUN);
            IO_HOLD_O <= (nxt_state != swc_pkg::SWC_RUN);
        end
    end

    // Instruction-side pulses: prefetch, resume, vector branch
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            PREFETCH_O <= 1'b0;
            RESUME_O <= 1'b0;
            VECTOR_BRANCH_O <= 1'b0;
            VECTOR_ADDR_O <= 13'h0000;
            wake_irq_ff <= 1'b0;
        end else begin
            PREFETCH_O <= sleep_entry;
            RESUME_O <= resume;
            VECTOR_BRANCH_O <= resume && wake_irq_ff && irq_en_ff[`SWC_IRQ_GIE];
            if (resume && wake_irq_ff && irq_en_ff[`SWC_IRQ_GIE]) begin
                VECTOR_ADDR_O <= `SWC_IRQ_VECTOR;
            end
            if (wake_start) begin
                wake_irq_ff <= irq_wake && !wdt_timeout;
            end
        end
    end

    // Internal reset from master clear or a running-state time-out;
    // the master clear pin is input only and is never driven
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            DEV_RESET_O <= 1'b0;
        end else begin
            DEV_RESET_O <= master_clear_pin || (wdt_timeout && state_ff == swc_pkg::SWC_RUN);
        end
    end

    // ---------------------------------------------------------------
    // Status flags
    // ---------------------------------------------------------------
    // Sets win over the time-out clear arriving in the same cycle
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            power_down_flag_ff <= 1'b1;
            timeout_flag_ff <= 1'b1;
        end else begin
            if (sleep_entry) begin
                power_down_flag_ff <= 1'b0;
            end else if (CLRWDT_I) begin
                power_down_flag_ff <= 1'b1;
            end
            if (sleep_entry || CLRWDT_I) begin
                timeout_flag_ff <= 1'b1;
            end else if (wdt_timeout) begin
                timeout_flag_ff <= 1'b0;
            end
        end
    end

    // Fuse word caught once after reset release
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            fuse_ff <= 8'h00;
            fuse_valid_ff <= 1'b0;
        end else if (!fuse_valid_ff) begin
            fuse_ff <= FUSE_I;
            fuse_valid_ff <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Register bus, write side
    // ---------------------------------------------------------------
    // Address and data taken in either order, answer when both held
    always_comb begin
        do_write = !S_AXI_AWREADY_O && !S_AXI_WREADY_O && !S_AXI_BVALID_O;
        wr_ok = (aw_idx_ff == `SWC_IDX_OPTION) || (aw_idx_ff == `SWC_IDX_IRQ_EN);
    end

    // Channel handshakes and write response
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            S_AXI_AWREADY_O <= 1'b1;
            S_AXI_WREADY_O <= 1'b1;
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O <= `SWC_RESP_OKAY;
            aw_idx_ff <= 14'h0000;
            wdata_ff <= 8'h00;
            wstrb0_ff <= 1'b0;
        end else begin
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                S_AXI_AWREADY_O <= 1'b0;
                aw_idx_ff <= S_AXI_AWADDR_I[15:2];
            end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
                S_AXI_AWREADY_O <= 1'b1;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                S_AXI_WREADY_O <= 1'b0;
                wdata_ff <= S_AXI_WDATA_I[7:0];
                wstrb0_ff <= S_AXI_WSTRB_I[0];
            end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
                S_AXI_WREADY_O <= 1'b1;
            end
            if (do_write) begin
                S_AXI_BVALID_O <= 1'b1;
                S_AXI_BRESP_O <= wr_ok ? `SWC_RESP_OKAY : `SWC_RESP_SLVERR;
            end else if (S_AXI_BREADY_I) begin
                S_AXI_BVALID_O <= 1'b0;
            end
        end
    end

    // Writable registers, low byte lane only
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            option_ff <= `SWC_OPTION_RST;
            irq_en_ff <= `SWC_IRQ_EN_RST;
        end else if (do_write && wstrb0_ff) begin
            if (aw_idx_ff == `SWC_IDX_OPTION) begin
                option_ff <= wdata_ff;
            end
            if (aw_idx_ff == `SWC_IDX_IRQ_EN) begin
                irq_en_ff <= wdata_ff & `SWC_IRQ_EN_MASK;
            end
        end
    end

    // ---------------------------------------------------------------
    // Register bus, read side
    // ---------------------------------------------------------------
    // Read decode, bits above the byte read as zero
    always_comb begin
        do_read = !S_AXI_ARREADY_O && !S_AXI_RVALID_O;
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        case (ar_idx_ff)
            `SWC_IDX_OPTION: rd_word[7:0] = option_ff;
            `SWC_IDX_FUSE: rd_word[7:0] = fuse_ff;
            `SWC_IDX_IRQ_EN: rd_word[7:0] = irq_en_ff;
            `SWC_IDX_STATUS: begin
                rd_word[`SWC_ST_TO] = timeout_flag_ff;
                rd_word[`SWC_ST_PD] = power_down_flag_ff;
                rd_word[`SWC_ST_WARM] = (state_ff == swc_pkg::SWC_WARM);
                rd_word[`SWC_ST_ASLEEP] = (state_ff == swc_pkg::SWC_SLEEP);
            end
            default: rd_ok = 1'b0;
        endcase
    end

    // Read handshakes and data
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            S_AXI_ARREADY_O <= 1'b1;
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O <= 32'h0000_0000;
            S_AXI_RRESP_O <= `SWC_RESP_OKAY;
            ar_idx_ff <= 14'h0000;
        end else begin
            if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
                S_AXI_ARREADY_O <= 1'b0;
                ar_idx_ff <= S_AXI_ARADDR_I[15:2];
            end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
                S_AXI_ARREADY_O <= 1'b1;
            end
            if (do_read) begin
                S_AXI_RVALID_O <= 1'b1;
                S_AXI_RDATA_O <= rd_word;
                S_AXI_RRESP_O <= rd_ok ? `SWC_RESP_OKAY : `SWC_RESP_SLVERR;
            end else if (S_AXI_RREADY_I) begin
                S_AXI_RVALID_O <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);

    // A clean wake from sleep into warm-up
    sequence s_wake;
        state_ff == swc_pkg::SWC_SLEEP && MASTER_CLEAR_PIN_N_I && wake
            ##1 state_ff == swc_pkg::SWC_WARM;
    endsequence

    chk_sleep_by_instr: assert property (
        $rose(state_ff == swc_pkg::SWC_SLEEP) |-> $past(SLEEP_EXEC_I))
        else $error("sleep entered without the instruction");
    chk_entry_flags: assert property (
        sleep_entry |=> !power_down_flag_ff && timeout_flag_ff && PREFETCH_O)
        else $error("flags or prefetch wrong after sleep entry");
    chk_osc_off: assert property (
        state_ff == swc_pkg::SWC_SLEEP |-> !OSC_DRIVER_ON_O && IO_HOLD_O)
        else $error("oscillator on or pins released while asleep");
    chk_wdt_wakes: assert property (
        state_ff == swc_pkg::SWC_SLEEP && wdt_timeout && MASTER_CLEAR_PIN_N_I
            |=> !DEV_RESET_O && state_ff == swc_pkg::SWC_WARM && !timeout_flag_ff)
        else $error("watchdog in sleep did not wake cleanly");
    chk_wdt_resets: assert property (
        state_ff == swc_pkg::SWC_RUN && wdt_timeout |=> DEV_RESET_O)
        else $error("watchdog time-out did not reset");
    chk_irq_wakes: assert property (
        state_ff == swc_pkg::SWC_SLEEP && irq_wake && MASTER_CLEAR_PIN_N_I
            |=> state_ff == swc_pkg::SWC_WARM)
        else $error("enabled interrupt did not wake");
    chk_delay_least: assert property (
        s_wake |-> !RESUME_O [*8])
        else $error("resumed before start-up delay");
    // Cycles spent in warm-up, saturating; bounds the wait for resume
    logic [10:0] warm_cnt_ff;
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I || state_ff != swc_pkg::SWC_WARM) begin
            warm_cnt_ff <= 11'h000;
        end else if (warm_cnt_ff != 11'h7ff) begin
            warm_cnt_ff <= warm_cnt_ff + 11'h001;
        end
    end
    chk_resume_bound: assert property (
        state_ff == swc_pkg::SWC_WARM |-> PIPE_FREEZE_O
            && warm_cnt_ff <= 11'(`SWC_XTAL_DELAY_CYC))
        else $error("no resume after start-up delay");
    chk_vector_gie: assert property (
        VECTOR_BRANCH_O |-> RESUME_O && $past(irq_en_ff[`SWC_IRQ_GIE]))
        else $error("vector branch without global enable");
endmodule
`default_nettype wire

// ---- swc_partner.sv ----
// Far-side model: watchdog slow oscillator and one interrupt source.
// Assumes clk_i is the core clock; flag bit 0 follows raise_i.
`timescale 1ns/1ps
`default_nettype none
module swc_partner (
    input wire logic clk_i,
    input wire logic raise_i,
    output logic tick_o,
    output logic [3:0] flag_o
);
    logic [2:0] div_ff = 3'h0; // Slow oscillator divider
    // Free-running divider, one tick each eight cycles
    always_ff @(posedge clk_i) begin
        div_ff <= div_ff + 3'h1;
    end
    assign tick_o = (div_ff == 3'h7);
    assign flag_o = {3'h0, raise_i};
endmodule
`default_nettype wire

// ---- tb_swc_top.sv ----
// Self-checking bench for the sleep and wake-up controller.
// Assumes swc_top and swc_partner are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "swc_map.svh"
module tb_swc_top;
    logic clk = 1'h0, rst_n = 1'h0, awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
    logic slp = 1'h0, master_clear_pin_n = 1'h1, raise = 1'h0;
    logic [15:0] awa = 16'h0, ara = 16'h0;
    logic [7:0] wd = 8'h0, fuse = 8'h03;
    logic awr, wrd, bv, arr, rv, tick, osc, frz, pre, hold, dres, res, vbr;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] flag;
    logic [12:0] vad;
    int bad_count = 0, n_compared = 0, n;
    always #50 clk = ~clk; // 10 MHz core clock
    swc_partner FAR (.clk_i(clk), .raise_i(raise), .tick_o(tick), .flag_o(flag));
    swc_top #(.WDT_BASE(2)) DUT (.CLOCK_I(clk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(awa),
        .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I({24'h0, wd}),
        .S_AXI_WSTRB_I(4'h1), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrd), .S_AXI_BRESP_O(bresp),
        .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
        .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
        .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr), .FUSE_I(fuse), .SLEEP_EXEC_I(slp),
        .CLRWDT_I(1'h0), .MASTER_CLEAR_PIN_N_I(master_clear_pin_n), .WDT_TICK_I(tick), .IRQ_FLAG_I(flag),
        .OSC_DRIVER_ON_O(osc), .PIPE_FREEZE_O(frz), .PREFETCH_O(pre), .IO_HOLD_O(hold),
        .DEV_RESET_O(dres), .RESUME_O(res), .VECTOR_BRANCH_O(vbr), .VECTOR_ADDR_O(vad));
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wrap_up;
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic tmo(input int k);
        if (k >= 99) begin
            bad_count++;
            wrap_up();
        end
    endtask
    // Bus write: address and data together, then response
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] e);
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'h1;
        wv <= 1'h1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!(awr && wrd) && n < 99);
        @(posedge clk);
        awv <= 1'h0;
        wv <= 1'h0;
        br <= 1'h1;
        do begin
            @(negedge clk);
            n++;
        end while (!bv && n < 99);
        tmo(n);
        chk("bresp", bresp, e);
        @(posedge clk);
        br <= 1'h0;
    endtask
    // Bus read with expected byte and response
    task automatic rd(input logic [15:0] a, input logic [7:0] d, input logic [1:0] e);
        @(posedge clk);
        ara <= a;
        arv <= 1'h1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!arr && n < 99);
        @(posedge clk);
        arv <= 1'h0;
        rr <= 1'h1;
        do begin
            @(negedge clk);
            n++;
        end while (!rv && n < 99);
        tmo(n);
        chk("rdata", rdata, {24'h0, d});
        chk("rresp", rresp, e);
        @(posedge clk);
        rr <= 1'h0;
    endtask
    // Sleep pulse and the entry effects
    task automatic nap;
        @(posedge clk);
        slp <= 1'h1;
        @(posedge clk);
        slp <= 1'h0;
        @(negedge clk);
        chk("prefetch", pre, 1'h1);
        chk("osc", osc, 1'h0);
        chk("hold", {frz, hold}, 2'h3);
    endtask
    // Count cycles up to resume
    task automatic wake;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!res && n < 99);
        tmo(n);
    endtask
    // Main sequence: reset values, enabled wake, pending wake, master clear
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        rd(16'h0204, 8'hff, `SWC_RESP_OKAY);
        rd(16'h000c, 8'h18, `SWC_RESP_OKAY);
        rd(16'h0ff0, 8'h00, `SWC_RESP_SLVERR);
        wr(16'h000c, 8'h00, `SWC_RESP_SLVERR);
        wr(16'h002c, 8'h01, `SWC_RESP_OKAY);
        nap();
        rd(16'h000c, 8'h11, `SWC_RESP_OKAY);
        @(posedge clk);
        raise <= 1'h1;
        wake();
        chk("delay", n, 13);
        chk("vector", {vbr, osc}, 2'h1);
        chk("release", {frz, hold}, 2'h0);
        wr(16'h002c, 8'h81, `SWC_RESP_OKAY);
        nap();
        wake();
        chk("vector", vbr, 1'h1);
        @(negedge clk);
        chk("vaddr", vad, `SWC_IRQ_VECTOR);
        @(posedge clk);
        master_clear_pin_n <= 1'h0;
        repeat (2) @(negedge clk);
        chk("reset", dres, 1'h1);
        // Second reset with the watchdog fused on and a short period
        @(posedge clk);
        rst_n <= 1'h0;
        master_clear_pin_n <= 1'h1;
        fuse <= 8'h0b;
        repeat (6) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        wr(16'h0204, 8'h00, `SWC_RESP_OKAY);
        nap();
        wake();
        chk("wdt wake", {vbr, dres}, 2'h0);
        rd(16'h000c, 8'h00, `SWC_RESP_OKAY);
        wrap_up();
    end
endmodule
`default_nettype wire
